// ### hw/sewp_top.sv
`timescale 1ns/1ps
`include "sewp_consts.svh"
// Notes on behaviour
// - input bits sampled on serial clock rise
// - output bit changes on serial clock fall
// - select high: output off, writes continue
// - first byte is instruction; unknown ignored
// - codes 06, 04, 05 decoded
// - codes 01, 03, 02 decoded
// - status layout: pin, zeros, guards, permit, busy
// - busy high for whole internal write
// - permit latch set and cleared by commands
// - guard bits select protected address range
// - protected never written; permit gates writes
// - 16-bit address, low 15 bits used
// - programming starts at select rising edge
// - while busy only status fetch acts
// - 64-byte page, in-page address wraps
// - write cycle end clears permit latch
// - status fetch while busy reads ff
// - status store changes bits 7,3,2 only
// - guard pin fall aborts pending status store when bit 7 is set
// - paused: output off, input ignored
// - invalid code: rest ignored, output off
// - read streams with address wrap-around
module sewp_top #(
    parameter int unsigned TWC_CYCLES = `SEWP_TWC_MS * 1000 * `SEWP_CLK_MHZ
) (
    // system
    input  wire logic clk,
    input  wire logic sys_rst,
    // serial link
    input  wire logic spi_sck,
    input  wire logic spi_cs_n,
    input  wire logic spi_si,
    input  wire logic spi_hold_n,
    input  wire logic spi_wp_n,
    output logic      spi_so,
    output logic      spi_so_oe
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    localparam int AW = `SEWP_ADDR_W;
    localparam int PW = `SEWP_PAGE_W;
    localparam int PD = 1 << PW;

    logic [7:0]             mem [0:(1 << AW) - 1];
    logic                   link_clr;
    // link domain
    logic [6:0]             sh;
    logic [2:0]             bitpos;
    logic [1:0]             byte_idx;
    logic [7:0]             byte_in;
    logic                   byte_end;
    logic                   frame_first;
    sewp_pkg::sewp_op_e     op;
    sewp_pkg::sewp_op_e     next_op;
    logic                   partial;
    logic [7:0]             addr_hi;
    logic [AW-1:0]          rd_ptr;
    logic [AW-PW-1:0]       wr_page;
    logic [PW-1:0]          wr_ptr;
    logic                   wr_seen;
    logic [7:0]             pbuf [0:PD-1];
    logic [PD-1:0]          pmask;
    logic [2:0]             st_val;
    logic                   st_seen;
    logic [4:0]             stat_s1;
    logic [4:0]             stat_s2;
    logic [7:0]             out_sh;
    logic                   out_on;
    logic [7:0]             stat_byte;
    // core domain
    logic [2:0]             cs_sync;
    logic [1:0]             wp_sync;
    logic                   commit;
    logic                   wp_low_seen;
    sewp_pkg::sewp_state_e  state;
    logic [PW:0]            prog_idx;
    logic [20:0]            twc_cnt;
    logic [AW-PW-1:0]       prog_page;
    logic                   permit;
    logic [1:0]             guard;
    logic                   guard_pin;
    logic                   busy;
    logic                   page_guarded;
    logic                   store_allowed;

    assign link_clr = spi_cs_n | sys_rst;

    // ------------------------------------------------------------
    // link domain: input shifting
    // ------------------------------------------------------------

    // assembled byte and its completion
    assign byte_in     = {sh, spi_si};
    assign byte_end    = (bitpos == 3'd7);
    assign frame_first = (byte_idx == 2'd0) && (bitpos == 3'd0);

    // bit and byte counters, cleared while deselected
    always_ff @(posedge spi_sck or posedge link_clr) begin
        if (link_clr) begin
            sh       <= 7'h00;
            bitpos   <= 3'h0;
            byte_idx <= 2'h0;
        end else if (spi_hold_n) begin
            sh     <= byte_in[6:0];
            bitpos <= bitpos + 3'd1;
            if (byte_end && byte_idx != 2'd3) begin
                byte_idx <= byte_idx + 2'd1;
            end
        end
    end

    // instruction decode; busy leaves only status fetch
    always_comb begin
        unique case (byte_in)
            `SEWP_OP_SET_PERMIT: next_op = sewp_pkg::SEWP_OP_SETP;
            `SEWP_OP_CLR_PERMIT: next_op = sewp_pkg::SEWP_OP_CLRP;
            `SEWP_OP_FETCH_STAT: next_op = sewp_pkg::SEWP_OP_FETCH;
            `SEWP_OP_STORE_STAT: next_op = sewp_pkg::SEWP_OP_STORE;
            `SEWP_OP_READ:       next_op = sewp_pkg::SEWP_OP_READ;
            `SEWP_OP_WRITE:      next_op = sewp_pkg::SEWP_OP_WRITE;
            default:             next_op = sewp_pkg::SEWP_OP_NONE;
        endcase
        if (stat_s2[`SEWP_ST_BUSY] && next_op != sewp_pkg::SEWP_OP_FETCH) begin
            next_op = sewp_pkg::SEWP_OP_NONE;
        end
    end

    // frame result: held through select high for the core
    always_ff @(posedge spi_sck or posedge sys_rst) begin
        if (sys_rst) begin
            op      <= sewp_pkg::SEWP_OP_NONE;
            partial <= 1'b0;
            st_val  <= 3'h0;
            st_seen <= 1'b0;
            wr_seen <= 1'b0;
        end else if (!spi_cs_n && spi_hold_n) begin
            partial <= !byte_end;
            if (frame_first) begin
                op      <= sewp_pkg::SEWP_OP_NONE;
                st_seen <= 1'b0;
                wr_seen <= 1'b0;
            end
            if (byte_end && byte_idx == 2'd0) begin
                op <= next_op;
            end
            if (byte_end && byte_idx == 2'd1 && op == sewp_pkg::SEWP_OP_STORE) begin
                st_val  <= {byte_in[`SEWP_ST_GUARD_PIN], byte_in[`SEWP_ST_GUARD_HI],
                            byte_in[`SEWP_ST_GUARD_LO]};
                st_seen <= 1'b1;
            end
            if (byte_end && byte_idx == 2'd3 && op == sewp_pkg::SEWP_OP_WRITE) begin
                wr_seen <= 1'b1;
            end
        end
    end

    // address capture and pointers for read and page load
    always_ff @(posedge spi_sck or posedge sys_rst) begin
        if (sys_rst) begin
            addr_hi <= 8'h00;
            rd_ptr  <= '0;
            wr_page <= '0;
            wr_ptr  <= '0;
        end else if (!spi_cs_n && spi_hold_n && byte_end) begin
            if (byte_idx == 2'd1) begin
                addr_hi <= byte_in;
            end
            if (byte_idx == 2'd2) begin
                rd_ptr  <= {addr_hi[AW-9:0], byte_in};
                wr_page <= {addr_hi[AW-9:0], byte_in[7:PW]};  // address bits 14:6
                wr_ptr  <= byte_in[PW-1:0];
            end
            if (byte_idx == 2'd3 && op == sewp_pkg::SEWP_OP_READ) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (byte_idx == 2'd3 && op == sewp_pkg::SEWP_OP_WRITE) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
        end
    end

    // page buffer with per-byte loaded marks
    always_ff @(posedge spi_sck or posedge sys_rst) begin
        if (sys_rst) begin
            pmask <= '0;
        end else if (!spi_cs_n && spi_hold_n && byte_end) begin
            if (byte_idx == 2'd0 && next_op == sewp_pkg::SEWP_OP_WRITE) begin
                pmask <= '0;
            end else if (byte_idx == 2'd3 && op == sewp_pkg::SEWP_OP_WRITE) begin
                pmask[wr_ptr] <= 1'b1;
            end
        end
    end

    // page buffer data
    always_ff @(posedge spi_sck) begin
        if (!spi_cs_n && spi_hold_n && byte_end && byte_idx == 2'd3 &&
            op == sewp_pkg::SEWP_OP_WRITE) begin
            pbuf[wr_ptr] <= byte_in;
        end
    end

    // status vector brought into the link domain
    always_ff @(posedge spi_sck or posedge sys_rst) begin
        if (sys_rst) begin
            stat_s1 <= 5'h00;
            stat_s2 <= 5'h00;
        end else begin
            stat_s1 <= {guard_pin, guard, permit, busy};
            stat_s2 <= stat_s1;
        end
    end

    // ------------------------------------------------------------
    // link domain: output shifting
    // ------------------------------------------------------------

    // status byte as shifted out
    assign stat_byte = stat_s2[0] ? `SEWP_ST_BUSY_BYTE :
                       {stat_s2[4], 3'b000, stat_s2[3:0]};

    // load a byte at each boundary after the instruction (fetch) or address (read), else shift on the fall
    always_ff @(negedge spi_sck or posedge link_clr) begin
        if (link_clr) begin
            out_sh <= 8'h00;
            out_on <= 1'b0;
        end else if (spi_hold_n) begin
            if (bitpos == 3'd0 && byte_idx != 2'd0 && op == sewp_pkg::SEWP_OP_FETCH) begin
                out_sh <= stat_byte;
                out_on <= 1'b1;
            end else if (bitpos == 3'd0 && byte_idx == 2'd3 && op == sewp_pkg::SEWP_OP_READ) begin
                out_sh <= mem[rd_ptr];
                out_on <= 1'b1;
            end else begin
                out_sh <= {out_sh[6:0], 1'b0};
            end
        end
    end

    // pin drive, dropped while paused or deselected
    assign spi_so    = out_sh[7];
    assign spi_so_oe = out_on && !spi_cs_n && spi_hold_n;

    // ------------------------------------------------------------
    // core domain: select and guard pin crossing
    // ------------------------------------------------------------

    // two flops per pin, third for select edge
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cs_sync <= 3'b111;
            wp_sync <= 2'b11;
        end else begin
            cs_sync <= {cs_sync[1:0], spi_cs_n};
            wp_sync <= {wp_sync[0], spi_wp_n};
        end
    end

    assign commit = cs_sync[1] && !cs_sync[2];

    // guard pin low seen during the open frame
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wp_low_seen <= 1'b0;
        end else if (!cs_sync[1] && !wp_sync[1]) begin
            wp_low_seen <= 1'b1;
        end else if (!cs_sync[1] && cs_sync[2]) begin
            wp_low_seen <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // core domain: protection and write cycle
    // ------------------------------------------------------------

    // guarded range check on the page address
    always_comb begin
        unique case (guard)
            2'b00:   page_guarded = 1'b0;
            2'b01:   page_guarded = &wr_page[AW-PW-1:AW-PW-2];
            2'b10:   page_guarded = wr_page[AW-PW-1];
            2'b11:   page_guarded = 1'b1;
        endcase
    end

    assign store_allowed = permit && !(guard_pin && (wp_low_seen || !wp_sync[1]));
    assign busy          = (state != sewp_pkg::SEWP_ST_IDLE);

    // write cycle sequencer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state     <= sewp_pkg::SEWP_ST_IDLE;
            prog_idx  <= '0;
            twc_cnt   <= '0;
            prog_page <= '0;
        end else begin
            unique case (state)
                sewp_pkg::SEWP_ST_IDLE: begin
                    prog_idx <= '0;
                    twc_cnt  <= '0;
                    if (commit && !partial && op == sewp_pkg::SEWP_OP_WRITE && wr_seen &&
                        permit && !page_guarded) begin
                        prog_page <= wr_page;
                        state     <= sewp_pkg::SEWP_ST_PROG;
                    end else if (commit && !partial && op == sewp_pkg::SEWP_OP_STORE &&
                                 st_seen && store_allowed) begin
                        state <= sewp_pkg::SEWP_ST_WAIT;
                    end
                end
                sewp_pkg::SEWP_ST_PROG: begin
                    prog_idx <= prog_idx + 1'b1;
                    if (prog_idx == PD[PW:0] - 1'b1) begin
                        state <= sewp_pkg::SEWP_ST_WAIT;
                    end
                end
                sewp_pkg::SEWP_ST_WAIT: begin
                    twc_cnt <= twc_cnt + 1'b1;
                    if (twc_cnt == TWC_CYCLES[20:0] - 1'b1) begin
                        state <= sewp_pkg::SEWP_ST_DONE;
                    end
                end
                sewp_pkg::SEWP_ST_DONE: begin
                    state <= sewp_pkg::SEWP_ST_IDLE;
                end
            endcase
        end
    end

    // array programming from the loaded page bytes
    always_ff @(posedge clk) begin
        if (state == sewp_pkg::SEWP_ST_PROG && pmask[prog_idx[PW-1:0]]) begin
            mem[{prog_page, prog_idx[PW-1:0]}] <= pbuf[prog_idx[PW-1:0]];
        end
    end

    // write permit latch
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            permit <= `SEWP_PERMIT_RST;
        end else if (state == sewp_pkg::SEWP_ST_DONE) begin
            permit <= 1'b0;
        end else if (state == sewp_pkg::SEWP_ST_IDLE && commit && !partial) begin
            if (op == sewp_pkg::SEWP_OP_SETP) begin
                permit <= 1'b1;
            end else if (op == sewp_pkg::SEWP_OP_CLRP) begin
                permit <= 1'b0;
            end
        end
    end

    // nonvolatile guard bits, taken when the store starts
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            guard     <= `SEWP_GUARD_RST;
            guard_pin <= `SEWP_GUARD_PIN_RST;
        end else if (state == sewp_pkg::SEWP_ST_IDLE && commit && !partial &&
                     op == sewp_pkg::SEWP_OP_STORE && st_seen && store_allowed) begin
            guard_pin <= st_val[2];
            guard     <= st_val[1:0];
        end
    end

endmodule : sewp_top

// ### hw/sewp_consts.svh
`ifndef SEWP_CONSTS_SVH
`define SEWP_CONSTS_SVH

// ------------------------------------------------------------
// instruction codes
// ------------------------------------------------------------
`define SEWP_OP_SET_PERMIT   8'h06
`define SEWP_OP_CLR_PERMIT   8'h04
`define SEWP_OP_FETCH_STAT   8'h05
`define SEWP_OP_STORE_STAT   8'h01
`define SEWP_OP_READ         8'h03
`define SEWP_OP_WRITE        8'h02

// ------------------------------------------------------------
// protection_status field positions
// ------------------------------------------------------------
`define SEWP_ST_GUARD_PIN    7
`define SEWP_ST_GUARD_HI     3
`define SEWP_ST_GUARD_LO     2
`define SEWP_ST_PERMIT       1
`define SEWP_ST_BUSY         0
`define SEWP_ST_BUSY_BYTE    8'hff

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define SEWP_GUARD_RST       2'h0
`define SEWP_GUARD_PIN_RST   1'b0
`define SEWP_PERMIT_RST      1'b0

// ------------------------------------------------------------
// array geometry and timing
// ------------------------------------------------------------
`define SEWP_ADDR_W          15
`define SEWP_PAGE_W          6
`define SEWP_TWC_MS          5
`define SEWP_CLK_MHZ         250

`endif

// ### hw/sewp_pkg.sv
package sewp_pkg;

    // decoded instruction
    typedef enum logic [2:0] {
        SEWP_OP_NONE  = 3'h0,
        SEWP_OP_SETP  = 3'h1,
        SEWP_OP_CLRP  = 3'h2,
        SEWP_OP_FETCH = 3'h3,
        SEWP_OP_STORE = 3'h4,
        SEWP_OP_READ  = 3'h5,
        SEWP_OP_WRITE = 3'h6
    } sewp_op_e;

    // internal write cycle states, gray along the page write path
    typedef enum logic [1:0] {
        SEWP_ST_IDLE = 2'b00,
        SEWP_ST_PROG = 2'b01,
        SEWP_ST_WAIT = 2'b11,
        SEWP_ST_DONE = 2'b10
    } sewp_state_e;

endpackage : sewp_pkg

// ### verification/sewp_host.sv
`timescale 1ns/1ps
// host serial controller model, 12 ns clock only inside frames
module sewp_host (
    // serial link
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    output logic      hold_n,
    input  wire logic so,
    input  wire logic so_oe
);
    logic mode3;   // clock parks high when set
    logic oe_seen; // output driven at any rise of this frame

    // idle link at time zero
    initial begin
        mode3 = 1'b0;
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        hold_n = 1'b1;
        oe_seen = 1'b0;
    end

    // open a frame with a falling select edge
    task start(input logic m3);
        mode3 = m3;
        sck = m3;
        oe_seen = 1'b0;
        #6 cs_n = 1'b0;
        #6;
    endtask : start

    // shift nb bits msb first, both sample on the rise; undriven line reads inverted
    task xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
        for (int i = 7; i > 7 - nb; i--) begin
            sck = 1'b0;
            si = tx[i];
            #6 sck = 1'b1;
            rx[i] = so_oe ? so : ~so;
            oe_seen |= so_oe;
            #6;
        end
    endtask : xfer

    // pause and resume, clock low at both changes, one pulse to be ignored
    task pause();
        sck = 1'b0;
        #6 hold_n = 1'b0;
        si = ~si;
        #6 sck = 1'b1;
        #6 sck = 1'b0;
        #18 hold_n = 1'b1;
        #6;
    endtask : pause

    // close with a rising select edge, data line left toggled
    task stop();
        sck = mode3;
        #6 cs_n = 1'b1;
        si = ~si;
        #30;
    endtask : stop
endmodule : sewp_host

// ### verification/sewp_sva.sv
`timescale 1ns/1ps
// port checker for the serial front end
module sewp_sva (
    // system
    input wire logic clk,
    input wire logic sys_rst,
    // serial link
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_si,
    input wire logic spi_hold_n,
    input wire logic spi_wp_n,
    input wire logic spi_so,
    input wire logic spi_so_oe
);
    logic [7:0] bits; // rises taken in this frame

    // count taken bits, cleared while deselected
    always_ff @(posedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) bits <= 8'h00;
        else if (spi_hold_n && bits != 8'hff) bits <= bits + 8'h01;
    end

    cs_off_a: assert property (@(posedge clk) disable iff (sys_rst) spi_cs_n |-> !spi_so_oe)
        else $error("output driven while deselected");
    hold_off_a: assert property (@(posedge clk) disable iff (sys_rst) !spi_hold_n |-> !spi_so_oe)
        else $error("output driven while paused");
    rst_off_a: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(sys_rst) |-> !spi_so_oe && !spi_so)
        else $error("output not quiet after reset");
    so_fall_a: assert property (@(posedge clk) disable iff (sys_rst)
        spi_so_oe && $past(spi_so_oe) && $changed(spi_so) |-> $fell(spi_sck))
        else $error("output bit changed without clock fall");
    oe_rise_a: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(spi_so_oe) |-> !spi_sck && !spi_cs_n)
        else $error("output enabled with clock high");
    op_quiet_a: assert property (@(posedge spi_sck) disable iff (sys_rst || spi_cs_n)
        bits < 8'h08 |-> !spi_so_oe)
        else $error("output during instruction byte");
    oe_late_a: assert property (@(posedge clk) disable iff (sys_rst) spi_so_oe |-> bits >= 8'h08)
        else $error("output before instruction complete");
    oe_keep_a: assert property (@(negedge spi_sck) disable iff (sys_rst || spi_cs_n)
        bits >= 8'h0a && $past(spi_so_oe) && spi_hold_n |-> spi_so_oe)
        else $error("output stream dropped mid frame");

    // main scenarios reached
    cover property (@(posedge clk) $rose(spi_so_oe));
    cover property (@(posedge clk) $fell(spi_hold_n) && $past(spi_so_oe));
    cover property (@(posedge clk) !spi_wp_n && !spi_cs_n);
endmodule : sewp_sva

// ### verification/sewp_top_tb.sv
`timescale 1ns/1ps
`include "sewp_consts.svh"
module sewp_top_tb;
    localparam int unsigned TWC = 200;  // busy outlasts the follow-up frames
    logic       clk, sys_rst, spi_wp_n;
    logic       spi_sck, spi_cs_n, spi_si, spi_hold_n, spi_so, spi_so_oe;
    logic [7:0] rx, jk;
    logic [7:0] d[$];
    int         mismatches, n_compared;

    sewp_top #(.TWC_CYCLES(TWC)) i_sewp_top (.clk(clk), .sys_rst(sys_rst), .spi_sck(spi_sck),
        .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_hold_n(spi_hold_n), .spi_wp_n(spi_wp_n),
        .spi_so(spi_so), .spi_so_oe(spi_so_oe));
    sewp_host i_sewp_host (.sck(spi_sck), .cs_n(spi_cs_n), .si(spi_si), .hold_n(spi_hold_n),
        .so(spi_so), .so_oe(spi_so_oe));

    // core clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // byte compare
    task chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8

    // one instruction-only frame
    task cmd(input logic [7:0] op);
        i_sewp_host.start(1'b0);
        i_sewp_host.xfer(op, 8, jk);
        i_sewp_host.stop();
    endtask : cmd

    // status fetch
    task stat(output logic [7:0] s);
        i_sewp_host.start(1'b0);
        i_sewp_host.xfer(`SEWP_OP_FETCH_STAT, 8, jk);
        i_sewp_host.xfer(8'h00, 8, s);
        i_sewp_host.stop();
    endtask : stat

    // poll until busy clears, bounded; a stuck busy counts
    task wait_ready();
        for (int i = 0; i < 20; i++) begin
            stat(rx);
            if (rx[`SEWP_ST_BUSY] === 1'b0) break;
        end
        chk8("busy after poll", 8'h00, {7'h00, rx[`SEWP_ST_BUSY]});
    endtask : wait_ready

    // opcode and 16-bit address
    task head(input logic [7:0] op, input logic [15:0] a);
        i_sewp_host.start(1'b0);
        i_sewp_host.xfer(op, 8, jk);
        i_sewp_host.xfer(a[15:8], 8, jk);
        i_sewp_host.xfer(a[7:0], 8, jk);
    endtask : head

    // permit then page write
    task wr(input logic [15:0] a, input logic [7:0] q[$]);
        cmd(`SEWP_OP_SET_PERMIT);
        head(`SEWP_OP_WRITE, a);
        foreach (q[i]) i_sewp_host.xfer(q[i], 8, jk);
        i_sewp_host.stop();
    endtask : wr

    // streaming read with compare of each byte
    task rd(input logic [15:0] a, input logic [7:0] e[$]);
        head(`SEWP_OP_READ, a);
        foreach (e[i]) begin
            i_sewp_host.xfer(8'h00, 8, rx);
            chk8("read data", e[i], rx);
        end
        i_sewp_host.stop();
    endtask : rd

    // permit then status store
    task sst(input logic [7:0] v);
        cmd(`SEWP_OP_SET_PERMIT);
        i_sewp_host.start(1'b0);
        i_sewp_host.xfer(`SEWP_OP_STORE_STAT, 8, jk);
        i_sewp_host.xfer(v, 8, jk);
        i_sewp_host.stop();
    endtask : sst

    task t_reset();
        stat(rx);
        chk8("status after reset", 8'h00, rx);
    endtask : t_reset

    task t_permit();
        cmd(`SEWP_OP_SET_PERMIT);
        stat(rx);
        chk8("status after permit set", 8'h02, rx);
        i_sewp_host.start(1'b1);
        i_sewp_host.xfer(`SEWP_OP_FETCH_STAT, 8, jk);
        i_sewp_host.pause();
        i_sewp_host.xfer(8'h00, 8, rx);
        i_sewp_host.stop();
        chk8("status in mode 3 with pause", 8'h02, rx);
        cmd(`SEWP_OP_CLR_PERMIT);
        stat(rx);
        chk8("status after permit clear", 8'h00, rx);
    endtask : t_permit

    task t_invalid();
        i_sewp_host.start(1'b0);
        i_sewp_host.xfer(8'haa, 8, jk);
        i_sewp_host.xfer(8'hff, 8, jk);
        i_sewp_host.stop();
        chk8("output enable on bad code", 8'h00, {7'h00, i_sewp_host.oe_seen});
        stat(rx);
        chk8("status after bad code", 8'h00, rx);
    endtask : t_invalid

    task t_page();
        d = {};
        for (int k = 0; k < 65; k++) d.push_back(8'(k + 1));
        wr(16'h8000, d);
        stat(rx);
        chk8("status while busy", `SEWP_ST_BUSY_BYTE, rx);
        sst(8'h8c);
        wait_ready();
        chk8("status after page write", 8'h00, rx);
        wr(16'h7fff, '{8'ha1, 8'hb2});
        wait_ready();
        rd(16'h7fff, '{8'ha1, 8'h41, 8'h02, 8'h03});
        rd(16'h7fc0, '{8'hb2});
    endtask : t_page

    task t_guard();
        @(posedge clk) #1 spi_wp_n = 1'b0;
        sst(8'hff);
        wait_ready();
        @(posedge clk) #1 spi_wp_n = 1'b1;
        chk8("status after store", 8'h8c, rx);
        wr(16'h0100, '{8'h55});
        stat(rx);
        chk8("status after guarded write", 8'h8e, rx);
        cmd(`SEWP_OP_SET_PERMIT);
        i_sewp_host.start(1'b0);
        i_sewp_host.xfer(`SEWP_OP_STORE_STAT, 8, jk);
        i_sewp_host.xfer(8'h84, 8, jk);
        @(posedge clk) #1 spi_wp_n = 1'b0;
        repeat (4) @(posedge clk);
        i_sewp_host.stop();
        @(posedge clk) #1 spi_wp_n = 1'b1;
        stat(rx);
        chk8("status after pin abort", 8'h8e, rx);
        sst(8'h84);
        wait_ready();
        chk8("status after quarter guard", 8'h84, rx);
        wr(16'h6000, '{8'h66});
        stat(rx);
        chk8("status after quarter refusal", 8'h86, rx);
        wr(16'h5fff, '{8'h3c});
        stat(rx);
        chk8("status after open write", `SEWP_ST_BUSY_BYTE, rx);
        wait_ready();
        rd(16'h5fff, '{8'h3c});
        cmd(`SEWP_OP_SET_PERMIT);
        head(`SEWP_OP_WRITE, 16'h1000);
        i_sewp_host.xfer(8'h99, 4, jk);
        i_sewp_host.stop();
        stat(rx);
        chk8("status after partial byte", 8'h86, rx);
    endtask : t_guard

    // counts and verdict
    task print_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    // reset then scenarios
    initial begin
        sys_rst = 1'b1;
        spi_wp_n = 1'b1;
        mismatches = 0;
        n_compared = 0;
        repeat (16) @(posedge clk);
        #1 sys_rst = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        t_reset();
        t_permit();
        t_invalid();
        t_page();
        t_guard();
        print_verdict();
    end

    // hang guard
    initial begin
        #200000;
        mismatches++;
        print_verdict();
    end
endmodule : sewp_top_tb

bind sewp_top sewp_sva i_sewp_sva (.clk(clk), .sys_rst(sys_rst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
    .spi_si(spi_si), .spi_hold_n(spi_hold_n), .spi_wp_n(spi_wp_n), .spi_so(spi_so), .spi_so_oe(spi_so_oe));
